//--- core/audio_capture_pkg.sv
package audio_capture_pkg;
   // Register indices; byte address on the bus is four times the index
   localparam logic [11:0] IDX_BASE_LO  = 12'h0b00;
   localparam logic [11:0] IDX_BASE_MID = 12'h0b01;
   localparam logic [11:0] IDX_DEPTH    = 12'h0b02;
   localparam logic [11:0] IDX_BASE_HI  = 12'h0b03;
   localparam logic [11:0] IDX_LOW_THR  = 12'h0b0c;
   localparam logic [11:0] IDX_HIGH_THR = 12'h0b0d;
   localparam logic [11:0] IDX_QCTRL    = 12'h0b10;
   localparam logic [11:0] IDX_CFG      = 12'h0b11;
   localparam logic [11:0] IDX_DECIM    = 12'h0b12;
   localparam logic [11:0] IDX_STATUS   = 12'h0b13;
   localparam logic [11:0] IDX_RPTR_LO  = 12'h0b14;
   localparam logic [11:0] IDX_RPTR_HI  = 12'h0b15;
   localparam logic [11:0] IDX_WPTR_LO  = 12'h0b16;
   localparam logic [11:0] IDX_WPTR_HI  = 12'h0b17;
   localparam logic [11:0] IDX_OCC_LO   = 12'h0b20;
   localparam logic [11:0] IDX_OCC_HI   = 12'h0b21;
   localparam logic [11:0] IDX_MODE     = 12'h0b2c;
   localparam logic [11:0] IDX_I2S_DIV  = 12'h0b30;
   localparam logic [11:0] IDX_FILTER   = 12'h0b40;
   localparam logic [11:0] IDX_ACTRL    = 12'h0560;

   // Reset values
   localparam logic [7:0] RST_BASE_MID = 8'h40;
   localparam logic [7:0] RST_DEPTH    = 8'h7f;
   localparam logic [7:0] RST_I2S_DIV  = 8'h40;

   // Field positions
   localparam int CFG_EDGE_LSB = 0;
   localparam int CFG_SRC_LSB  = 2;
   localparam int CFG_MONO     = 4;
   localparam int CFG_DEC_BYP  = 5;
   localparam int CFG_MASK_LSB = 6;
   localparam int QC_LOW_IE    = 4;
   localparam int QC_HIGH_IE   = 5;
   localparam int ST_LOW       = 0;
   localparam int ST_HIGH      = 1;
   localparam int ST_LOW_STK   = 4;
   localparam int ST_HIGH_STK  = 5;
   localparam int FLT_HPF_BYP  = 4;
   localparam int FLT_LPF_BYP  = 6;
   localparam int FLT_DOWN     = 7;
   localparam int AC_PLAY      = 1;
   localparam int AC_ISO       = 3;
   localparam int AC_REC       = 4;
   localparam int AC_IFACE     = 5;
   localparam int MODE_MANUAL  = 0;

   typedef enum logic [1:0] {SRC_USB, SRC_SERIAL, SRC_ANALOG, SRC_PDM} src_sel_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } apb_rsp_t;

   typedef struct packed {
      logic        vld;
      logic        ch;
      logic [15:0] data;
   } sample_t;

   typedef struct packed {
      logic        vld;
      logic [15:0] ch0;
      logic [15:0] ch1;
      logic [15:0] ch2;
   } analog_t;

   typedef struct packed {
      logic        vld;
      logic [1:0]  queue;
      logic [23:0] addr;
      logic [15:0] data;
   } mem_wr_t;

   typedef struct packed {
      logic [7:0]       base_lo, base_mid, base_hi, depth, low_thr, high_thr;
      logic [7:0]       qctrl, cfg, decim, status, mode, flt, actrl, i2s_div;
      logic [15:0]      wptr, rptr;
      logic             pready, pslverr;
      logic [31:0]      prdata;
      logic             pdm_s1, pdm_s2, i2s_s1, i2s_s2;
      logic [7:0]       pdm_cnt, bclk_cnt;
      logic             pdm_clk, bclk, lrclk;
      logic [3:0]       bit_cnt;
      logic [15:0]      shreg;
      logic             raw_vld, ana1_vld;
      logic [15:0]      raw_data, ana1_data;
      sample_t          smp, pout;
      logic [1:0][31:0] acc;
      logic [1:0][8:0]  dcnt;
      logic [1:0][15:0] lpf_prev, hpf_dc;
      logic [1:0]       ds_ph;
      mem_wr_t          mem;
      logic             low_irq, high_irq;
   } core_st_t;

   localparam core_st_t ST_RESET = '{default: '0, base_mid: RST_BASE_MID,
                                     depth: RST_DEPTH, i2s_div: RST_I2S_DIV};

   // Ratio codes 0..7 give 1..8, 8..12 give 16..256
   function automatic logic [8:0] decim_ratio(input logic [3:0] code);
      if (code < 4'h8) return {5'h00, code} + 9'h001;
      if (code < 4'hd) return 9'h001 << (code - 4'h4);
      return 9'h001;
   endfunction : decim_ratio
endpackage : audio_capture_pkg

//--- core/audio_input_path_dma_fifo.sv
`timescale 1ns/10ps
module audio_input_path_dma_fifo #(
   parameter logic [7:0] PDM_HALF = 8'h20
) (
   // Clock and reset
   input  wire logic                        sys_clk_in,
   input  wire logic                        rst_in,
   // APB slave
   input  wire audio_capture_pkg::apb_req_t apb_in,
   output audio_capture_pkg::apb_rsp_t      apb_out,
   // Pulse-density microphone
   input  wire logic                        pdm_data_in,
   output logic                             pdm_clk_out,
   // Serial audio codec
   input  wire logic                        i2s_data_in,
   output logic                             i2s_bclk_out,
   output logic                             i2s_lrclk_out,
   // USB stream and converter, same clock
   input  wire audio_capture_pkg::sample_t  usb_in,
   input  wire audio_capture_pkg::analog_t  analog_in,
   // Queue memory side
   input  wire logic                        dma_rd_in,
   output audio_capture_pkg::mem_wr_t       mem_out,
   // Status and playback enables
   output logic                             queue_low_irq_out,
   output logic                             queue_high_irq_out,
   output logic                             playback_en_out,
   output logic                             iso_playback_en_out
);
   import audio_capture_pkg::*;

   core_st_t    st_reg;
   core_st_t    st_next;
   logic [15:0] depth_b;
   logic [15:0] occ;
   logic [13:0] occ_w;
   logic        live_low;
   logic        live_high;
   logic [11:0] idx;
   logic        hit;
   logic [7:0]  rd_val;
   logic        wr;
   logic [7:0]  wd;
   logic        clr_low;
   logic        clr_high;
   src_sel_t    src;

   // Queue geometry and level, in bytes
   assign depth_b   = {4'h0, st_reg.depth, 4'h0};
   assign occ       = (st_reg.wptr >= st_reg.rptr) ? st_reg.wptr - st_reg.rptr
                      : st_reg.wptr + depth_b - st_reg.rptr;
   assign occ_w     = occ[15:2];
   assign live_low  = occ_w < {6'h00, st_reg.low_thr};
   assign live_high = occ_w > {6'h00, st_reg.high_thr};
   assign src       = src_sel_t'(st_reg.cfg[CFG_SRC_LSB +: 2]);

   // Bus decode; write lands on the completing access edge
   assign idx      = apb_in.paddr[13:2];
   assign wd       = apb_in.pwdata[7:0];
   assign wr       = apb_in.psel & apb_in.penable & st_reg.pready & apb_in.pwrite & apb_in.pstrb[0] & hit;
   assign clr_low  = wr & (idx == IDX_STATUS) & wd[ST_LOW_STK];
   assign clr_high = wr & (idx == IDX_STATUS) & wd[ST_HIGH_STK];

   // Read mux; unmapped or misaligned answers with an error
   always_comb begin
      rd_val = 8'h00;
      hit    = (apb_in.paddr[1:0] == 2'b00) && (apb_in.paddr[15:14] == 2'b00);
      case (idx)
         IDX_BASE_LO:  rd_val = st_reg.base_lo;
         IDX_BASE_MID: rd_val = st_reg.base_mid;
         IDX_DEPTH:    rd_val = st_reg.depth;
         IDX_BASE_HI:  rd_val = st_reg.base_hi;
         IDX_LOW_THR:  rd_val = st_reg.low_thr;
         IDX_HIGH_THR: rd_val = st_reg.high_thr;
         IDX_QCTRL:    rd_val = st_reg.qctrl;
         IDX_CFG:      rd_val = st_reg.cfg;
         IDX_DECIM:    rd_val = st_reg.decim;
         IDX_STATUS:   rd_val = st_reg.status;
         IDX_RPTR_LO:  rd_val = st_reg.rptr[7:0];
         IDX_RPTR_HI:  rd_val = st_reg.rptr[15:8];
         IDX_WPTR_LO:  rd_val = st_reg.wptr[7:0];
         IDX_WPTR_HI:  rd_val = st_reg.wptr[15:8];
         IDX_OCC_LO:   rd_val = occ[7:0];
         IDX_OCC_HI:   rd_val = occ[15:8];
         IDX_MODE:     rd_val = st_reg.mode;
         IDX_I2S_DIV:  rd_val = st_reg.i2s_div;
         IDX_FILTER:   rd_val = st_reg.flt;
         IDX_ACTRL:    rd_val = st_reg.actrl;
         default:      hit = 1'b0;
      endcase
   end

   // Whole next-state function
   always_comb begin
      logic               c;
      logic               v;
      logic [15:0]        x;
      logic [31:0]        a;
      logic [8:0]         k;
      logic signed [31:0] sh;
      logic [16:0]        t17;
      logic signed [16:0] d17;
      logic signed [16:0] step;
      logic [1:0]         q;
      logic [15:0]        wnext;
      logic               pdm_rise;
      logic               pdm_fall;
      logic               word_done;
      sample_t            s;
      c         = st_reg.smp.ch;
      v         = 1'b0;
      x         = st_reg.smp.data;
      a         = 32'h0000_0000;
      k         = 9'h000;
      sh        = 32'sh0000_0000;
      t17       = 17'h0_0000;
      d17       = 17'sh0_0000;
      step      = 17'sh0_0000;
      q         = 2'd0;
      wnext     = 16'h0000;
      pdm_rise  = 1'b0;
      pdm_fall  = 1'b0;
      word_done = 1'b0;
      s         = '0;
      st_next   = st_reg;

      // Register writes; status, pointers and level are not plain storage
      if (wr) begin
         case (idx)
            IDX_BASE_LO:  st_next.base_lo = wd;
            IDX_BASE_MID: st_next.base_mid = wd;
            IDX_DEPTH:    st_next.depth = wd;
            IDX_BASE_HI:  st_next.base_hi = wd;
            IDX_LOW_THR:  st_next.low_thr = wd;
            IDX_HIGH_THR: st_next.high_thr = wd;
            IDX_QCTRL:    st_next.qctrl = wd & 8'h37;
            IDX_CFG:      st_next.cfg = wd;
            IDX_DECIM:    st_next.decim = wd;
            IDX_MODE:     st_next.mode = wd & 8'h01;
            IDX_I2S_DIV:  st_next.i2s_div = wd;
            IDX_FILTER:   st_next.flt = wd;
            IDX_ACTRL:    st_next.actrl = wd & 8'h3a;
            IDX_RPTR_LO:  if (st_reg.mode[MODE_MANUAL]) st_next.rptr[7:0] = wd;
            IDX_RPTR_HI:  if (st_reg.mode[MODE_MANUAL]) st_next.rptr[15:8] = wd;
            default:      ;
         endcase
      end

      // No wait state: data and ready registered in the setup cycle
      st_next.pready  = apb_in.psel & ~apb_in.penable;
      st_next.pslverr = apb_in.psel & ~apb_in.penable & ~hit;
      st_next.prdata  = {24'h00_0000, rd_val};

      // Two-flop synchronisers on the pins
      st_next.pdm_s1 = pdm_data_in;
      st_next.pdm_s2 = st_reg.pdm_s1;
      st_next.i2s_s1 = i2s_data_in;
      st_next.i2s_s2 = st_reg.i2s_s1;

      // Microphone clock runs only while its source is chosen
      if (src == SRC_PDM) begin
         if (st_reg.pdm_cnt >= PDM_HALF - 8'h01) begin
            st_next.pdm_cnt = 8'h00;
            st_next.pdm_clk = ~st_reg.pdm_clk;
            pdm_rise        = ~st_reg.pdm_clk;
            pdm_fall        = st_reg.pdm_clk;
         end else begin
            st_next.pdm_cnt = st_reg.pdm_cnt + 8'h01;
         end
      end else begin
         st_next.pdm_cnt = 8'h00;
         st_next.pdm_clk = 1'b0;
      end

      // Serial audio master; half bit period is divider plus one
      if (st_reg.actrl[AC_IFACE]) begin
         if (st_reg.bclk_cnt >= st_reg.i2s_div) begin
            st_next.bclk_cnt = 8'h00;
            st_next.bclk     = ~st_reg.bclk;
            if (!st_reg.bclk) begin
               st_next.shreg   = {st_reg.shreg[14:0], st_reg.i2s_s2};
               st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
               word_done       = (st_reg.bit_cnt == 4'hf);
            end else if (st_reg.bit_cnt == 4'h0) begin
               st_next.lrclk = ~st_reg.lrclk;
            end
         end else begin
            st_next.bclk_cnt = st_reg.bclk_cnt + 8'h01;
         end
      end else begin
         st_next.bclk_cnt = 8'h00;
         st_next.bclk     = 1'b0;
         st_next.lrclk    = 1'b0;
         st_next.bit_cnt  = 4'h0;
      end

      // Source selection into one sample stream
      case (src)
         SRC_USB: s = usb_in;
         SRC_SERIAL: begin
            s.vld  = word_done & st_reg.actrl[AC_REC];
            s.ch   = st_reg.lrclk;
            s.data = {st_reg.shreg[14:0], st_reg.i2s_s2};
         end
         SRC_ANALOG: begin
            // Second channel waits a cycle so one sample enters per clock
            if (analog_in.vld) begin
               s                 = '{vld: 1'b1, ch: 1'b0, data: analog_in.ch0};
               st_next.ana1_vld  = 1'b1;
               st_next.ana1_data = analog_in.ch1;
            end else if (st_reg.ana1_vld) begin
               s                = '{vld: 1'b1, ch: 1'b1, data: st_reg.ana1_data};
               st_next.ana1_vld = 1'b0;
            end
         end
         SRC_PDM: begin
            // Edge code 11 is treated as rising only, never both
            s.vld  = (pdm_rise & st_reg.cfg[CFG_EDGE_LSB] & st_reg.cfg[CFG_MASK_LSB])
                     | (pdm_fall & (st_reg.cfg[1:0] == 2'b10) & st_reg.cfg[CFG_MASK_LSB + 1]);
            s.ch   = pdm_fall;
            s.data = st_reg.pdm_s2 ? 16'h0001 : 16'hffff;
         end
         default: s = '0;
      endcase
      st_next.smp = s;

      // Decimation; the shift keeps the accumulated sum in range
      v = st_reg.smp.vld & ~(st_reg.cfg[CFG_MONO] & c);
      if (v && !st_reg.cfg[CFG_DEC_BYP]) begin
         a = st_reg.acc[c] + {{16{x[15]}}, x};
         k = st_reg.dcnt[c] + 9'h001;
         if (k >= decim_ratio(st_reg.decim[3:0])) begin
            sh                 = $signed(a) >>> st_reg.decim[7:4];
            x                  = sh[15:0];
            st_next.acc[c]     = 32'h0000_0000;
            st_next.dcnt[c]    = 9'h000;
         end else begin
            v                  = 1'b0;
            st_next.acc[c]     = a;
            st_next.dcnt[c]    = k;
         end
      end
      // Two-tap average as compensation low-pass
      if (v && !st_reg.flt[FLT_LPF_BYP]) begin
         t17                 = {x[15], x} + {st_reg.lpf_prev[c][15], st_reg.lpf_prev[c]};
         st_next.lpf_prev[c] = x;
         x                   = t17[16:1];
      end
      if (v && st_reg.flt[FLT_DOWN]) begin
         st_next.ds_ph[c] = ~st_reg.ds_ph[c];
         v                = st_reg.ds_ph[c];
      end
      // Offset tracker; larger tuning value means slower tracking
      if (v && !st_reg.flt[FLT_HPF_BYP]) begin
         d17               = $signed({x[15], x}) - $signed({st_reg.hpf_dc[c][15], st_reg.hpf_dc[c]});
         step              = d17 >>> st_reg.flt[3:0];
         st_next.hpf_dc[c] = st_reg.hpf_dc[c] + step[15:0];
         x                 = d17[15:0];
      end
      st_next.pout = '{vld: v, ch: c, data: x};

      // Queue write port; processed data has priority over raw channel
      st_next.mem.vld = 1'b0;
      if (st_reg.pout.vld || st_reg.raw_vld) begin
         q = st_reg.pout.vld ? {1'b0, st_reg.pout.ch} : 2'd2;
         if (!st_reg.pout.vld) st_next.raw_vld = 1'b0;
         st_next.mem.queue = q;
         st_next.mem.data  = st_reg.pout.vld ? st_reg.pout.data : st_reg.raw_data;
         st_next.mem.addr  = 24'h00_0000;
         if (q == 2'd0) begin
            if (st_reg.qctrl[0] && (occ + 16'h0002 < depth_b)) begin
               st_next.mem.vld  = 1'b1;
               st_next.mem.addr = {st_reg.base_hi, st_reg.base_mid, st_reg.base_lo}
                                  + {8'h00, st_reg.wptr};
               wnext            = st_reg.wptr + 16'h0002;
               st_next.wptr     = (wnext >= depth_b) ? 16'h0000 : wnext;
            end
         end else begin
            st_next.mem.vld = st_reg.qctrl[q];
         end
      end
      // Raw channel two; a new sample wins over the clear above
      if (src == SRC_ANALOG && analog_in.vld) begin
         st_next.raw_vld  = 1'b1;
         st_next.raw_data = analog_in.ch2;
      end

      // Consumer reads one word at a time in auto mode
      if (dma_rd_in && !st_reg.mode[MODE_MANUAL] && occ >= 16'h0004) begin
         wnext        = st_reg.rptr + 16'h0004;
         st_next.rptr = (wnext >= depth_b) ? 16'h0000 : wnext;
      end

      // Level flags: live first, sticky one cycle later, set beats clear
      st_next.status              = 8'h00;
      st_next.status[ST_LOW]      = live_low;
      st_next.status[ST_HIGH]     = live_high;
      st_next.status[ST_LOW_STK]  = (st_reg.status[ST_LOW_STK] & ~clr_low) | st_reg.status[ST_LOW];
      st_next.status[ST_HIGH_STK] = (st_reg.status[ST_HIGH_STK] & ~clr_high) | st_reg.status[ST_HIGH];
      st_next.low_irq             = st_reg.status[ST_LOW_STK] & st_reg.qctrl[QC_LOW_IE];
      st_next.high_irq            = st_reg.status[ST_HIGH_STK] & st_reg.qctrl[QC_HIGH_IE];
   end

   // State register
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st_reg <= ST_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs, all straight from state
   assign apb_out             = '{pready: st_reg.pready, prdata: st_reg.prdata, pslverr: st_reg.pslverr};
   assign pdm_clk_out         = st_reg.pdm_clk;
   assign i2s_bclk_out        = st_reg.bclk;
   assign i2s_lrclk_out       = st_reg.lrclk;
   assign mem_out             = st_reg.mem;
   assign queue_low_irq_out   = st_reg.low_irq;
   assign queue_high_irq_out  = st_reg.high_irq;
   assign playback_en_out     = st_reg.actrl[AC_PLAY];
   assign iso_playback_en_out = st_reg.actrl[AC_ISO];

   // Checks
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   property p_low_live;
      live_low |=> st_reg.status[ST_LOW];
   endproperty
   a_low_live: assert property (p_low_live) else $error("live low flag missed");
   property p_low_clear;
      !live_low |=> !st_reg.status[ST_LOW];
   endproperty
   a_low_clear: assert property (p_low_clear) else $error("live low did not clear");
   property p_low_seq;
      live_low ##1 1'b1 |=> st_reg.status[ST_LOW_STK];
   endproperty
   a_low_seq: assert property (p_low_seq) else $error("sticky low not set after live");
   property p_low_irq;
      st_reg.status[ST_LOW_STK] && st_reg.qctrl[QC_LOW_IE] |=> queue_low_irq_out;
   endproperty
   a_low_irq: assert property (p_low_irq) else $error("low interrupt missing");
   property p_high_live;
      live_high |=> st_reg.status[ST_HIGH] ##1 st_reg.status[ST_HIGH_STK];
   endproperty
   a_high_live: assert property (p_high_live) else $error("high flags wrong");
   property p_high_clear;
      !live_high |=> !st_reg.status[ST_HIGH];
   endproperty
   a_high_clear: assert property (p_high_clear) else $error("live high did not clear");
   property p_sticky_hold;
      st_reg.status[ST_LOW_STK] && !clr_low |=> st_reg.status[ST_LOW_STK];
   endproperty
   a_sticky_hold: assert property (p_sticky_hold) else $error("sticky low lost");
   property p_gate_q2;
      mem_out.vld && mem_out.queue == 2'd2 |-> $past(st_reg.qctrl[2]);
   endproperty
   a_gate_q2: assert property (p_gate_q2) else $error("write to disabled queue");
   property p_occ_bound;
      $stable(st_reg.depth) && !st_reg.mode[MODE_MANUAL] && occ <= depth_b |=> $changed(st_reg.depth) || occ <= depth_b;
   endproperty
   a_occ_bound: assert property (p_occ_bound) else $error("occupancy above depth");
   property p_mono;
      mem_out.vld |-> !(mem_out.queue == 2'd1 && $past(st_reg.cfg[CFG_MONO], 2));
   endproperty
   a_mono: assert property (p_mono) else $error("mono wrote second queue");
   property p_pdm_idle;
      src != SRC_PDM |=> !pdm_clk_out;
   endproperty
   a_pdm_idle: assert property (p_pdm_idle) else $error("mic clock runs unselected");

   c_low_stk: cover property ($rose(st_reg.status[ST_LOW_STK]));
   c_high_stk: cover property ($rose(st_reg.status[ST_HIGH_STK]));
   c_raw_q2: cover property (mem_out.vld && mem_out.queue == 2'd2);
   c_wrap: cover property (mem_out.vld && mem_out.queue == 2'd0 && st_reg.wptr == 16'h0000);
endmodule : audio_input_path_dma_fifo

//--- verification/audio_far_side_model.sv
`timescale 1ns/10ps
module audio_far_side_model (
   // Clocks from the capture block
   input  wire logic pdm_clk_in,
   input  wire logic bclk_in,
   // Data lines back to it
   output logic      pdm_data_out,
   output logic      i2s_data_out
);
   logic        bit_reg  = 1'b0;
   logic [15:0] word_reg = 16'ha5c3;
   logic        pdm_live = 1'b0;
   logic        bclk_live = 1'b0;
   // Unknown to low at reset is no real fall; arm on a first rise
   always @(posedge pdm_clk_in) pdm_live <= 1'b1;
   always @(posedge bclk_in) bclk_live <= 1'b1;
   // Mic toggles on the falling clock, so every rising sample sees a fresh bit
   always @(negedge pdm_clk_in) if (pdm_live) bit_reg <= ~bit_reg;
   // Codec shifts MSB first on the falling bit clock, settled for the rise
   always @(negedge bclk_in) if (bclk_live) word_reg <= {word_reg[14:0], word_reg[15]};
   assign pdm_data_out = bit_reg;
   assign i2s_data_out = word_reg[15];
endmodule : audio_far_side_model

//--- verification/testbench.sv
`timescale 1ns/10ps
module testbench;
   import audio_capture_pkg::*;
   logic       sys_clk = 1'b0, rst = 1'b1, dma_rd = 1'b0, err;
   apb_req_t   req = '0;
   apb_rsp_t   rsp;
   sample_t    usb = '0;
   analog_t    ana = '0;
   mem_wr_t    mem;
   logic       pdm_clk, pdm_dat, bclk, lrclk, i2s_dat, low_irq, high_irq, play_en, iso_en;
   logic [7:0] q;
   int         error_cnt = 0, check_count = 0;
   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;
   // Short mic clock keeps the far side busy in a short run
   audio_input_path_dma_fifo #(.PDM_HALF(8'h04)) dut_u (
      .sys_clk_in(sys_clk), .rst_in(rst), .apb_in(req), .apb_out(rsp), .pdm_data_in(pdm_dat),
      .pdm_clk_out(pdm_clk), .i2s_data_in(i2s_dat), .i2s_bclk_out(bclk), .i2s_lrclk_out(lrclk),
      .usb_in(usb), .analog_in(ana), .dma_rd_in(dma_rd), .mem_out(mem), .queue_low_irq_out(low_irq),
      .queue_high_irq_out(high_irq), .playback_en_out(play_en), .iso_playback_en_out(iso_en));
   audio_far_side_model far_u (.pdm_clk_in(pdm_clk), .bclk_in(bclk), .pdm_data_out(pdm_dat),
      .i2s_data_out(i2s_dat));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Idle edge first, so a release and the next setup never share a time step
   task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'b00, idx, 2'b00},
               pwdata: {24'h00_0000, d}, pstrb: 4'h1};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      // No local limit; only the watchdog ends a wait
      do begin
         @(posedge sys_clk);
      end while (rsp.pready !== 1'b1);
      q = rsp.prdata[7:0];
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(q, exp);
   endtask : rd
   // Bounded watch of the queue port; keeps the first write seen
   task automatic watch(input int n, output logic hit, output logic [17:0] got, output logic [23:0] adr);
      hit = 1'b0;
      repeat (n) begin
         @(posedge sys_clk);
         if (mem.vld === 1'b1 && !hit) begin
            hit = 1'b1;
            got = {mem.queue, mem.data};
            adr = mem.addr;
         end
      end
   endtask : watch
   // One USB sample, then a bounded watch of the queue port
   task automatic usb_send(input logic [15:0] d, output logic hit, output logic [17:0] got,
                           output logic [23:0] adr);
      @(posedge sys_clk);
      usb <= '{vld: 1'b1, ch: 1'b0, data: d};
      @(posedge sys_clk);
      usb.vld <= 1'b0;
      watch(10, hit, got, adr);
   endtask : usb_send
   task automatic t_regs();
      rd(IDX_BASE_MID, RST_BASE_MID);
      rd(IDX_DEPTH, RST_DEPTH);
      apb(1'b1, 12'h0bff, 8'h5a);
      chk(err, 1'b1);
      apb(1'b1, IDX_ACTRL, 8'h0a);
      // Write lands on the edge the task returns at; look one edge later
      @(posedge sys_clk);
      chk({play_en, iso_en}, 2'b11);
   endtask : t_regs
   // Filters and decimator bypassed so the sample lands unchanged
   task automatic t_queue();
      logic        h;
      logic [17:0] g;
      logic [23:0] a;
      apb(1'b1, IDX_FILTER, 8'h50);
      apb(1'b1, IDX_CFG, 8'h20);
      usb_send(16'h1234, h, g, a);
      chk(h, 1'b0);
      apb(1'b1, IDX_QCTRL, 8'h01);
      usb_send(16'hbeef, h, g, a);
      chk({h, g}, {1'b1, 2'b00, 16'hbeef});
      chk(a, 24'h00_4000);
      rd(IDX_WPTR_LO, 8'h02);
      rd(IDX_OCC_LO, 8'h02);
   endtask : t_queue
   // Two bytes held is zero words, below a threshold of two
   task automatic t_flags();
      apb(1'b1, IDX_QCTRL, 8'h11);
      apb(1'b1, IDX_LOW_THR, 8'h02);
      repeat (4) @(posedge sys_clk);
      rd(IDX_STATUS, 8'h11);
      chk(low_irq, 1'b1);
      apb(1'b1, IDX_STATUS, 8'h00);
      rd(IDX_STATUS, 8'h11);
      apb(1'b1, IDX_LOW_THR, 8'h00);
      rd(IDX_STATUS, 8'h10);
      apb(1'b1, IDX_STATUS, 8'h10);
      rd(IDX_STATUS, 8'h00);
      chk(low_irq, 1'b0);
   endtask : t_flags
   // Raw channel two skips the pipeline and reaches its queue first
   task automatic t_analog();
      logic        h;
      logic [17:0] g;
      logic [23:0] a;
      apb(1'b1, IDX_CFG, 8'h28);
      apb(1'b1, IDX_QCTRL, 8'h07);
      @(posedge sys_clk);
      ana <= '{vld: 1'b1, ch0: 16'h1111, ch1: 16'h2222, ch2: 16'h3333};
      @(posedge sys_clk);
      ana.vld <= 1'b0;
      watch(10, h, g, a);
      chk({h, g}, {1'b1, 2'b10, 16'h3333});
   endtask : t_analog
   // Rising channel, ratio three, no shift: -1 +1 -1 sums to -1 in the low bits with or without sign extension
   task automatic t_pdm();
      logic        h;
      logic [17:0] g;
      logic [23:0] a;
      apb(1'b1, IDX_DECIM, 8'h02);
      apb(1'b1, IDX_CFG, 8'h4d);
      watch(40, h, g, a);
      chk({h, g}, {1'b1, 2'b00, 16'hffff});
   endtask : t_pdm
   // Fast bit clock; first word is left channel, then the frame flips
   task automatic t_serial();
      logic        h;
      logic [17:0] g;
      logic [23:0] a;
      apb(1'b1, IDX_I2S_DIV, 8'h03);
      apb(1'b1, IDX_CFG, 8'h24);
      apb(1'b1, IDX_QCTRL, 8'h23);
      apb(1'b1, IDX_ACTRL, 8'h30);
      watch(200, h, g, a);
      chk({h, g}, {1'b1, 2'b00, 16'ha5c3});
      chk(lrclk, 1'b1);
      chk(pdm_clk, 1'b0);
      rd(IDX_STATUS, 8'h22);
      chk(high_irq, 1'b1);
      @(posedge sys_clk);
      dma_rd <= 1'b1;
      @(posedge sys_clk);
      dma_rd <= 1'b0;
      rd(IDX_RPTR_LO, 8'h04);
   endtask : t_serial
   // Reset in mid-run returns clocks, flags and pointers to rest
   task automatic t_reset();
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      chk({bclk, lrclk, pdm_clk, high_irq}, 4'h0);
      rd(IDX_RPTR_LO, 8'h00);
   endtask : t_reset
   task automatic summarize();
      $display("Checks %0d, errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_queue();
      t_flags();
      t_analog();
      t_pdm();
      t_serial();
      t_reset();
      summarize();
   end
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end
endmodule : testbench
